// file: logic/ebt_params.svh
`ifndef EBT_PARAMS_SVH
`define EBT_PARAMS_SVH

// ****************************************************************
// timing counts in half device clocks (one link clock each); the CLK ones after EBT_HALVES_PER_CLK count whole clocks; EBT_BEAT_W is the beat counter width
// ****************************************************************
`define EBT_HALVES_PER_CLK 5'h02
`define EBT_LATCH_NARROW_H 5'h01
`define EBT_LATCH_WIDE_H 5'h03
`define EBT_LATCH_GAP_H 5'h01
`define EBT_CODE_STRETCH_H 5'h04
`define EBT_MIN_STRETCH_READ_H 5'h04
`define EBT_MIN_SETUP_H 5'h02
`define EBT_WRITE_BASE_CLK 5'h02
`define EBT_LATCHED_BASE_CLK 5'h02
`define EBT_UNLATCHED_BASE_CLK 5'h01
`define EBT_WSTROBE_SHORT_CLK 5'h01
`define EBT_WSTROBE_LONG_CLK 5'h02
`define EBT_WHOLD_EXT_CLK 5'h01
`define EBT_BEAT_W 2

`endif

// file: logic/ebt_pkg.sv
package ebt_pkg;

    typedef enum logic [1:0] {
        EBT_CODE = 2'h0,
        EBT_READ = 2'h1,
        EBT_WRITE = 2'h2
    } ebt_kind_e;

    typedef enum logic [0:0] {
        ST_IDLE = 1'h0,
        ST_RUN = 1'h1
    } ebt_state_e;

    typedef logic [4:0] ebt_half_t;

endpackage : ebt_pkg

// file: logic/ebt_bus_timing.sv
`timescale 1ns/1ns
`include "ebt_params.svh"
module ebt_bus_timing #(
    parameter int BEAT_W = `EBT_BEAT_W
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_link,
    input wire logic i_req_valid,
    input wire ebt_pkg::ebt_kind_e i_req_kind,
    input wire logic i_req_latched,
    input wire logic [BEAT_W-1:0] i_req_beats_m1,
    input wire logic i_req_low_byte,
    input wire logic i_req_high_byte,
    input wire logic i_latch_pulse_wide,
    input wire logic [1:0] i_nonlatched_code_cycle_len,
    input wire logic [1:0] i_latched_code_cycle_len,
    input wire logic [1:0] i_unlatched_read_len,
    input wire logic [1:0] i_latched_read_len,
    input wire logic [1:0] i_unlatched_write_len,
    input wire logic [1:0] i_latched_write_len,
    input wire logic i_write_hold_extend,
    input wire logic i_write_strobe_long,
    input wire logic i_wait,
    output logic o_busy,
    output logic o_done,
    output logic o_cfg_invalid,
    output logic o_bus_clock_output,
    output logic o_latch_strobe,
    output logic o_code_fetch_strobe_n,
    output logic o_read_strobe_n,
    output logic o_write_strobe_low_byte_n,
    output logic o_write_strobe_high_byte_n,
    output logic o_data_drive,
    output logic o_lowest_address_line
);
    import ebt_pkg::*;

    initial begin
        if (BEAT_W < 1 || BEAT_W > 4) begin
            $error("BEAT_W must be 1 to 4");
        end
    end

    // ****************************************************************
    // shared arithmetic
    // ****************************************************************
    function automatic ebt_half_t cyc_len(input logic [1:0] code, input ebt_half_t base);
        cyc_len = ebt_half_t'({3'h0, code}) + base;
    endfunction : cyc_len

    function automatic ebt_half_t halves(input ebt_half_t clks);
        halves = ebt_half_t'(clks << 1);
    endfunction : halves

    // ****************************************************************
    // system side: request checking and capture
    // ****************************************************************
    ebt_kind_e kind_q;
    logic lat_q, lo_q, hi_q;
    logic [BEAT_W-1:0] beats_q;
    ebt_half_t t_first_d, t_next_d, w_h_d, ws_d, wh_d;
    ebt_half_t t_first_q, t_next_q, w_h_q, ws_q, wh_q;
    logic valid_d;
    logic req_tgl_q, ack_s1_q, ack_s2_q, ack_seen_q;
    logic ack_tgl_q;

    always_comb begin
        ebt_half_t dstart;
        dstart = '0;
        w_h_d = i_latch_pulse_wide ? `EBT_LATCH_WIDE_H : `EBT_LATCH_NARROW_H;
        ws_d = i_write_strobe_long ? `EBT_WSTROBE_LONG_CLK : `EBT_WSTROBE_SHORT_CLK;
        wh_d = i_write_hold_extend ? `EBT_WHOLD_EXT_CLK : 5'h00;
        unique case (i_req_kind)
            EBT_CODE: begin
                t_first_d = i_req_latched ? cyc_len(i_latched_code_cycle_len,
                    `EBT_LATCHED_BASE_CLK) : cyc_len(i_nonlatched_code_cycle_len,
                    `EBT_UNLATCHED_BASE_CLK);
                t_next_d = cyc_len(i_nonlatched_code_cycle_len, `EBT_UNLATCHED_BASE_CLK);
            end
            EBT_READ: begin
                t_first_d = i_req_latched ? cyc_len(i_latched_read_len,
                    `EBT_LATCHED_BASE_CLK) : cyc_len(i_unlatched_read_len,
                    `EBT_UNLATCHED_BASE_CLK);
                t_next_d = cyc_len(i_unlatched_read_len, `EBT_UNLATCHED_BASE_CLK);
            end
            default: begin
                t_first_d = i_req_latched ? cyc_len(i_latched_write_len,
                    `EBT_WRITE_BASE_CLK) : cyc_len(i_unlatched_write_len, `EBT_WRITE_BASE_CLK);
                t_next_d = cyc_len(i_unlatched_write_len, `EBT_WRITE_BASE_CLK);
            end
        endcase
        valid_d = 1'b1;
        if (i_req_kind == EBT_WRITE) begin
            if (!i_write_hold_extend) begin
                valid_d = 1'b0;
            end
            dstart = i_req_latched ? w_h_d + `EBT_LATCH_GAP_H : 5'h00;
            if (halves(t_first_d - ws_d - wh_d) < dstart + `EBT_MIN_SETUP_H
                || halves(t_next_d - ws_d - wh_d) < `EBT_MIN_SETUP_H) begin
                valid_d = 1'b0;
            end
        end else if (i_req_kind == EBT_CODE || i_req_kind == EBT_READ) begin
            if (i_req_latched && halves(t_first_d) <= w_h_d + `EBT_LATCH_GAP_H) begin
                valid_d = 1'b0;
            end
        end else begin
            valid_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        ack_s1_q <= ack_tgl_q;
        ack_s2_q <= ack_s1_q;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_cfg_invalid <= 1'b0;
            req_tgl_q <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_cfg_invalid <= 1'b0;
            if (o_busy && (ack_s2_q ^ ack_seen_q)) begin
                ack_seen_q <= ack_s2_q;
                o_busy <= 1'b0;
                o_done <= 1'b1;
            end else if (!o_busy && i_req_valid) begin
                if (!valid_d) begin
                    o_done <= 1'b1;
                    o_cfg_invalid <= 1'b1;
                end else begin
                    o_busy <= 1'b1;
                    req_tgl_q <= ~req_tgl_q;
                end
            end
        end
    end

    // fields stay put while busy, so the link side may read them after the toggle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            kind_q <= EBT_CODE;
            lat_q <= 1'b0;
            beats_q <= '0;
            lo_q <= 1'b0;
            hi_q <= 1'b0;
            t_first_q <= '0;
            t_next_q <= '0;
            w_h_q <= '0;
            ws_q <= '0;
            wh_q <= '0;
        end else if (!o_busy && i_req_valid && valid_d) begin
            kind_q <= i_req_kind;
            lat_q <= i_req_latched;
            beats_q <= i_req_beats_m1;
            lo_q <= i_req_low_byte;
            hi_q <= i_req_high_byte;
            t_first_q <= t_first_d;
            t_next_q <= t_next_d;
            w_h_q <= w_h_d;
            ws_q <= ws_d;
            wh_q <= wh_d;
        end
    end

    // ****************************************************************
    // link side: synchronisers
    // ****************************************************************
    logic rst_s1_q, rst_link_q;
    logic req_s1_q, req_s2_q, req_seen_q;
    logic wait_s1_q, wait_s2_q;

    always_ff @(posedge i_clk_link) begin
        rst_s1_q <= i_rst;
        rst_link_q <= rst_s1_q;
        req_s1_q <= req_tgl_q;
        req_s2_q <= req_s1_q;
        wait_s1_q <= i_wait;
        wait_s2_q <= wait_s1_q;
    end

    // ****************************************************************
    // link side: half-clock cycle engine
    // ****************************************************************
    ebt_state_e state_q;
    ebt_half_t h_q, tot_h, rs_start, ws_end, ws_start, d_start, stall_pt;
    logic [BEAT_W-1:0] beat_q;
    logic lat_run_q, hold_q, stretch_ok, stall;

    always_comb begin
        tot_h = halves(lat_run_q ? t_first_q : t_next_q);
        rs_start = lat_run_q ? w_h_q + `EBT_LATCH_GAP_H : 5'h00;
        ws_end = halves(tot_h[4:1] - wh_q);
        ws_start = ws_end - halves(ws_q) - 5'h01;
        d_start = rs_start;
        stall_pt = (kind_q == EBT_WRITE) ? ws_end - `EBT_HALVES_PER_CLK
            : tot_h - `EBT_HALVES_PER_CLK;
        stretch_ok = (kind_q == EBT_CODE) ? (tot_h - rs_start >= `EBT_CODE_STRETCH_H - 5'h02)
            : (kind_q == EBT_READ) ? (tot_h - rs_start >= `EBT_MIN_STRETCH_READ_H) : 1'b1;
        // even half: sample wait; odd half: repeat the decision to keep phase
        stall = state_q == ST_RUN && h_q == stall_pt && stretch_ok
            && (o_bus_clock_output ? hold_q : wait_s2_q);
    end

    always_ff @(posedge i_clk_link) begin
        if (rst_link_q) begin
            o_bus_clock_output <= 1'b0;
        end else begin
            o_bus_clock_output <= ~o_bus_clock_output;
        end
    end

    always_ff @(posedge i_clk_link) begin
        if (rst_link_q) begin
            state_q <= ST_IDLE;
            h_q <= '0;
            beat_q <= '0;
            lat_run_q <= 1'b0;
            hold_q <= 1'b0;
            req_seen_q <= 1'b0;
            ack_tgl_q <= 1'b0;
        end else begin
            hold_q <= stall;
            unique case (state_q)
                ST_IDLE: begin
                    // start so that half zero lines up with a bus clock rising edge
                    if ((req_s2_q ^ req_seen_q) && o_bus_clock_output) begin
                        req_seen_q <= req_s2_q;
                        state_q <= ST_RUN;
                        h_q <= '0;
                        beat_q <= '0;
                        lat_run_q <= lat_q;
                    end
                end
                ST_RUN: begin
                    if (!stall) begin
                        if (h_q == tot_h - 5'h01) begin
                            if (beat_q == beats_q) begin
                                state_q <= ST_IDLE;
                                ack_tgl_q <= ~ack_tgl_q;
                            end else begin
                                beat_q <= beat_q + BEAT_W'(1);
                                h_q <= '0;
                                lat_run_q <= 1'b0;
                            end
                        end else begin
                            h_q <= h_q + 5'h01;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // link side: pin drivers, one link clock behind the engine
    // ****************************************************************
    logic run;
    assign run = state_q == ST_RUN;

    always_ff @(posedge i_clk_link) begin
        if (rst_link_q) begin
            o_latch_strobe <= 1'b0;
            o_code_fetch_strobe_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_write_strobe_low_byte_n <= 1'b1;
            o_write_strobe_high_byte_n <= 1'b1;
            o_data_drive <= 1'b0;
            o_lowest_address_line <= 1'b0;
        end else begin
            o_latch_strobe <= run && lat_run_q && h_q < w_h_q;
            // unlatched beats start at half zero, so burst strobes never lift
            o_code_fetch_strobe_n <= !(run && kind_q == EBT_CODE && h_q >= rs_start);
            o_read_strobe_n <= !(run && kind_q == EBT_READ && h_q >= rs_start);
            o_write_strobe_low_byte_n <= !(run && kind_q == EBT_WRITE && lo_q
                && h_q >= ws_start && h_q < ws_end);
            o_write_strobe_high_byte_n <= !(run && kind_q == EBT_WRITE && hi_q
                && h_q >= ws_start && h_q < ws_end);
            o_data_drive <= run && kind_q == EBT_WRITE && h_q >= d_start;
            o_lowest_address_line <= run && beat_q[0];
        end
    end

endmodule : ebt_bus_timing

// file: tb/ebt_bus_timing_properties.sv
`timescale 1ns/1ns
module ebt_bus_timing_properties (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_clk_link,
    input wire logic i_req_valid,
    input wire ebt_pkg::ebt_kind_e i_req_kind,
    input wire logic i_latch_pulse_wide,
    input wire logic i_write_hold_extend,
    input wire logic i_write_strobe_long,
    input wire logic o_busy,
    input wire logic o_done,
    input wire logic o_cfg_invalid,
    input wire logic o_bus_clock_output,
    input wire logic o_latch_strobe,
    input wire logic o_code_fetch_strobe_n,
    input wire logic o_read_strobe_n,
    input wire logic o_write_strobe_low_byte_n,
    input wire logic o_data_drive
);
    import ebt_pkg::*;
    // ****************************************************************
    // strobe timing in the link domain, request refusal in the system domain; config levels are held per transfer
    // ****************************************************************
    chk_latch_narrow: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $rose(o_latch_strobe) && !i_latch_pulse_wide |=> !o_latch_strobe) else $error("latch narrow");
    chk_latch_wide: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $rose(o_latch_strobe) && i_latch_pulse_wide |=> o_latch_strobe ##1 o_latch_strobe
        ##1 !o_latch_strobe) else $error("latch wide width");
    chk_latch_gap: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $fell(o_latch_strobe) && i_req_kind != EBT_WRITE |-> o_read_strobe_n && o_code_fetch_strobe_n
        ##1 !(o_read_strobe_n && o_code_fetch_strobe_n)) else $error("strobe after latch gap");
    chk_rise_edge: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $changed(o_read_strobe_n) || $changed(o_code_fetch_strobe_n) || $rose(o_latch_strobe)
        |-> $rose(o_bus_clock_output)) else $error("strobe not on bus clock rise");
    chk_write_fall: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $fell(o_write_strobe_low_byte_n) |-> $fell(o_bus_clock_output)) else $error("write edge");
    chk_write_short: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $fell(o_write_strobe_low_byte_n) && !i_write_strobe_long |-> !o_write_strobe_low_byte_n[*3]
        ##1 o_write_strobe_low_byte_n) else $error("short write width");
    chk_write_long: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $fell(o_write_strobe_low_byte_n) && i_write_strobe_long |-> !o_write_strobe_low_byte_n[*5]
        ##1 o_write_strobe_low_byte_n) else $error("long write width");
    chk_write_hold: assert property (@(posedge i_clk_link) disable iff (i_rst)
        $rose(o_write_strobe_low_byte_n) |-> o_data_drive[*2]) else $error("write data hold");
    chk_refuse_hold: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_req_valid && !o_busy && i_req_kind == EBT_WRITE && !i_write_hold_extend
        |=> o_done && o_cfg_invalid) else $error("write without hold accepted");
    chk_refuse_kind: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_req_valid && !o_busy && i_req_kind == 2'h3 |=> o_done && o_cfg_invalid)
        else $error("unknown kind accepted");
    cover property (@(posedge i_clk_link) $rose(o_latch_strobe) && i_latch_pulse_wide);
    cover property (@(posedge i_clk_link) $fell(o_write_strobe_low_byte_n));
    cover property (@(posedge i_clk_sys) o_cfg_invalid);
endmodule : ebt_bus_timing_properties

bind ebt_bus_timing ebt_bus_timing_properties i_props (.*);

// file: tb/ebt_ext_mem.sv
`timescale 1ns/1ns
module ebt_ext_mem (
    input wire logic i_clk_link,
    input wire logic i_stall_en,
    input wire logic i_bus_clock_output,
    input wire logic i_read_strobe_n,
    input wire logic i_code_fetch_strobe_n,
    input wire logic i_lowest_address_line,
    output logic o_wait
);
    // ****************************************************************
    // slow peripheral: asks for wait states at each read or code strobe fall, or when the lowest address line rises
    // ****************************************************************
    logic rd_q = 1'b1;
    logic cd_q = 1'b1;
    logic a0_q = 1'b0;
    logic [2:0] hold_q = 3'h0;
    initial o_wait = 1'b0;
    always @(posedge i_clk_link) begin
        rd_q <= i_read_strobe_n;
        cd_q <= i_code_fetch_strobe_n;
        a0_q <= i_lowest_address_line;
        // later beats have no strobe edge, so the address line rise restarts the wait
        if (i_stall_en && ((rd_q && !i_read_strobe_n) || (cd_q && !i_code_fetch_strobe_n)
            || (!a0_q && i_lowest_address_line))) begin
            hold_q <= 3'h4;
        end else if (hold_q != 3'h0 && i_bus_clock_output) begin
            hold_q <= hold_q - 3'h1;
        end
        // wait moves only as the bus clock falls, so it is steady across its rise
        if (i_bus_clock_output) begin
            o_wait <= (hold_q != 3'h0);
        end
    end
endmodule : ebt_ext_mem

// file: tb/ebt_bus_timing_tb.sv
`timescale 1ns/1ns
module ebt_bus_timing_tb;
    import ebt_pkg::*;
    logic clk_sys = 1'b0, clk_link = 1'b0, rst = 1'b1, valid = 1'b0, lat = 1'b0;
    logic lb = 1'b1, hb = 1'b0, wide = 1'b0, hold_ext = 1'b1, wlong = 1'b0, stall_en = 1'b0;
    logic [1:0] beats = 2'h0, len = 2'h0;
    ebt_kind_e kind = EBT_CODE;
    logic busy, done, inv, bclk, latch, cd_n, rd_n, wl_n, wh_n, dd, a0, wt, p_st, p_a0;
    int cnt [0:7];
    int err_count = 0;
    int n_checks = 0;
    always #10 clk_sys = !clk_sys;
    always #6 clk_link = !clk_link;
    ebt_bus_timing i_dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_link(clk_link),
        .i_req_valid(valid), .i_req_kind(kind), .i_req_latched(lat), .i_req_beats_m1(beats),
        .i_req_low_byte(lb), .i_req_high_byte(hb), .i_latch_pulse_wide(wide),
        .i_nonlatched_code_cycle_len(len), .i_latched_code_cycle_len(len),
        .i_unlatched_read_len(len), .i_latched_read_len(len), .i_unlatched_write_len(len),
        .i_latched_write_len(len), .i_write_hold_extend(hold_ext), .i_write_strobe_long(wlong),
        .i_wait(wt), .o_busy(busy), .o_done(done), .o_cfg_invalid(inv),
        .o_bus_clock_output(bclk), .o_latch_strobe(latch), .o_code_fetch_strobe_n(cd_n),
        .o_read_strobe_n(rd_n), .o_write_strobe_low_byte_n(wl_n),
        .o_write_strobe_high_byte_n(wh_n), .o_data_drive(dd), .o_lowest_address_line(a0));
    ebt_ext_mem i_mem (.i_clk_link(clk_link), .i_stall_en(stall_en), .i_bus_clock_output(bclk),
        .i_read_strobe_n(rd_n), .i_code_fetch_strobe_n(cd_n), .i_lowest_address_line(a0),
        .o_wait(wt));
    // ****************************************************************
    // pin activity counted in half bus clocks; strobe starts and address line rises counted once each
    // ****************************************************************
    always @(posedge clk_link) begin
        cnt[0] += int'(!rd_n);
        cnt[1] += int'(!cd_n);
        cnt[2] += int'(!wl_n);
        cnt[3] += int'(!wh_n);
        cnt[4] += int'(latch);
        cnt[5] += int'(dd);
        cnt[6] += int'(p_st && !(rd_n && cd_n));
        cnt[7] += int'(!p_a0 && a0);
        p_st <= rd_n && cd_n;
        p_a0 <= a0;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic op(input ebt_kind_e k, input logic l, input logic [1:0] b, input logic e_inv);
        @(posedge clk_sys) #1;
        kind = k;
        lat = l;
        beats = b;
        valid = 1'b1;
        cnt = '{default: 0};
        @(posedge clk_sys) #1;
        valid = 1'b0;
        check(busy, !e_inv);
        for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk_sys) #1;
        check(done, 1'b1);
        check(inv, e_inv);
    endtask : op
    task automatic stop_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        #200000;
        err_count++;
        stop_test();
    end
    initial begin
        int w, e;
        repeat (6) @(posedge clk_sys);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk_sys);
        for (int k = 0; k < 2; k++) for (int l = 0; l < 2; l++) for (int x = 0; x < 2; x++) begin
            for (int c = 0; c < 4; c++) begin
                wide = x[0];
                len = c[1:0];
                w = x ? 3 : 1;
                // a wide latch in the shortest latched cycle leaves no strobe at all
                e = int'(l == 1 && x == 1 && c == 0);
                op(ebt_kind_e'(k), l[0], 2'h0, e[0]);
                check(cnt[1 - k], l ? 2 * (c + 2) - w - 1 : 2 * (c + 1));
                check(cnt[4], (l == 1 && e == 0) ? w : 0);
            end
        end
        wide = 1'b0;
        len = 2'h1;
        for (int k = 0; k < 2; k++) begin
            op(ebt_kind_e'(k), 1'b1, 2'h1, 1'b0);
            check(cnt[1 - k], 8);
            check(cnt[6], 1);
            check(cnt[7], 1);
        end
        len = 2'h3;
        for (int l = 0; l < 2; l++) for (int x = 0; x < 2; x++) begin
            wlong = x[0];
            hb = x[0];
            op(EBT_WRITE, l[0], 2'h0, 1'b0);
            check(cnt[2], x ? 5 : 3);
            check(cnt[3], x ? 5 : 0);
            check(cnt[5], l ? 8 : 10);
        end
        hold_ext = 1'b0;
        op(EBT_WRITE, 1'b0, 2'h0, 1'b1);
        check(cnt[2] + cnt[5], 0);
        hold_ext = 1'b1;
        wide = 1'b1;
        op(EBT_WRITE, 1'b1, 2'h0, 1'b1);
        check(cnt[4], 0);
        op(ebt_kind_e'(2'h3), 1'b0, 2'h0, 1'b1);
        check(cnt[0] + cnt[1], 0);
        stall_en = 1'b1;
        op(EBT_READ, 1'b0, 2'h0, 1'b0);
        check(cnt[0] > 8 && cnt[0] % 2 == 0, 1'b1);
        len = 2'h0;
        op(EBT_READ, 1'b0, 2'h0, 1'b0);
        check(cnt[0], 2);
        stop_test();
    end
endmodule : ebt_bus_timing_tb
